//--- src/adcr_pkg.sv
// Shared constants and types for the audio delay configuration bank
package adcr_pkg;

	// Register offsets
	localparam logic [7:0] ADCR_OFS_CTRL    = 8'h01;
	localparam logic [7:0] ADCR_OFS_R_HIGH  = 8'h02;
	localparam logic [7:0] ADCR_OFS_R_LOW   = 8'h03;
	localparam logic [7:0] ADCR_OFS_L_HIGH  = 8'h04;
	localparam logic [7:0] ADCR_OFS_L_LOW   = 8'h05;
	localparam logic [7:0] ADCR_OFS_FRAME   = 8'h06;
	localparam logic [7:0] ADCR_OFS_WORDLEN = 8'h07;
	localparam logic [7:0] ADCR_OFS_COMMIT  = 8'h08;

	// Reset value and read value of unmapped offsets
	localparam logic [7:0] ADCR_RST_BYTE    = 8'h00;
	localparam logic [7:0] ADCR_UNMAPPED_RD = 8'h00;

	// Field positions and widths
	localparam int ADCR_MUTE_R_BIT    = 7;
	localparam int ADCR_MUTE_L_BIT    = 6;
	localparam int ADCR_FMT_LSB       = 0;
	localparam int ADCR_FMT_W         = 2;
	localparam int ADCR_HIGH_W        = 5;
	localparam int ADCR_DELAY_W       = 13;
	localparam int ADCR_FRAME_EN_BIT  = 7;
	localparam int ADCR_FRAME_59_BIT  = 6;
	localparam int ADCR_FS_SEL_LSB    = 3;
	localparam int ADCR_FS_SEL_W      = 3;
	localparam int ADCR_NFRAME_LSB    = 0;
	localparam int ADCR_NFRAME_W      = 3;
	localparam int ADCR_WORDLEN_W     = 6;
	localparam int ADCR_COMMIT_BIT    = 0;
	localparam int ADCR_SAMPLE_W      = 24;
	localparam int ADCR_FIFO_DEPTH    = 32;
	localparam int ADCR_PROD_W        = 24;

	localparam logic [12:0] ADCR_DELAY_MAX   = 13'h1fff;
	localparam logic [5:0]  ADCR_WORDLEN_MAX = 6'h18;

	// Frame conversion: sample rates in units of 100 Hz
	localparam logic [10:0] ADCR_FS_100HZ [0:7] = '{11'h140, 11'h1b9, 11'h1e0, 11'h372,
		11'h3c0, 11'h6e4, 11'h780, 11'h780};
	// 50 Hz: fs/50 = fs100 * 2; 59.94 Hz: fs/59.94 = fs100 * 1001 / 600
	localparam logic [10:0] ADCR_MUL_50 = 11'h002;
	localparam logic [10:0] ADCR_MUL_59 = 11'h3e9;
	localparam logic [23:0] ADCR_DIV_59 = 24'h000258;

	typedef enum logic [1:0] {
		ADCR_FMT_I2S,
		ADCR_FMT_RIGHT_JUSTIFIED,
		ADCR_FMT_LEFT_JUSTIFIED,
		ADCR_FMT_BYPASS
	} adcr_fmt_e;

	typedef struct packed {
		logic                     right;
		logic [ADCR_SAMPLE_W-1:0] data;
	} adcr_sample_s;

	typedef struct packed {
		adcr_fmt_e                format;
		logic                     bypass;
		logic [ADCR_WORDLEN_W-1:0] word_len;
		logic [ADCR_DELAY_W-1:0]  delay_right;
		logic [ADCR_DELAY_W-1:0]  delay_left;
	} adcr_setting_s;

endpackage

//--- src/adcr_bank.sv
// Register bank, frame-delay conversion and sample FIFO of the audio delay block
// Overview of operation
// [RL1] Host acks each read byte except the last, then ends the transfer.
// [RL2] Sequential reads return successive registers from the selected one while acked.
// [RL3] Each channel delay: upper register holds 5 bits, lower register 8 bits.
// [RL4] Control bits 7:6 mute: 00 none, 01 left, 10 right, 11 both.
// [RL5] Control bits 1:0 format: 00 I2S, 01 right-justified, 10 left-justified.
// [RL6] Format 11 is bypass: audio forwarded without delay.
// [RL7] Channel delay is 13-bit unsigned count of sample periods.
// [RL8] Largest sample delay is 8191 per channel.
// [RL9] Delay zero adds nothing; delay one adds one sample period.
// [RL10] Host should write control then four delay bytes in one burst.
// [RL11] Frame register bit 7 set selects frame-derived delay, else channel registers.
// [RL12] Frame bit 6 picks frame rate: 0 is 50 Hz, 1 is 59.94 Hz.
// [RL13] Frame bits 5:3 pick sample rate 32k to 192k, 110 and 111 both 192k.
// [RL14] Frame bits 2:0 plus one give frames of delay, one to eight.
// [RL15] Frame delay in samples is integer of frames times fs over frame rate.
// [RL16] Frame-derived delay above 8191 is clamped to 8191.
// [RL17] Delay, frame, format, length apply on commit bit 0 write; mute applies at once.
// [RL18] Muted channel carries zero samples while framing continues.
// [RL19] Upper three bits of upper delay registers ignored on write, read zero.
`timescale 1ns/1ps
`default_nettype none

module adcr_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr_ptr;
		logic [AW-1:0]               rd_ptr;
		logic [AW:0]                 count;
	} adcr_fifo_s;

	adcr_fifo_s state_reg;
	adcr_fifo_s state_next;
	logic       push;
	logic       pop;

	assign in_ready  = (state_reg.count != (AW+1)'(DEPTH));
	assign out_valid = (state_reg.count != '0);
	assign out_data  = state_reg.mem[state_reg.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb
	begin
		state_next = state_reg;
		if (push)
		begin
			state_next.mem[state_reg.wr_ptr] = in_data;
			state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
		end
		if (pop)
			state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
		case ({push, pop})
			2'b10:   state_next.count = state_reg.count + 1'b1;
			2'b01:   state_next.count = state_reg.count - 1'b1;
			default: state_next.count = state_reg.count;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end
endmodule // adcr_fifo

module adcr_bank (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Register access from the serial control engine
	input  wire logic                  reg_addr_load,
	input  wire logic [7:0]            reg_addr_in,
	input  wire logic                  reg_wr_stb,
	input  wire logic [7:0]            reg_wr_data,
	input  wire logic                  reg_rd_stb,
	output logic      [7:0]            reg_rd_data,
	output logic      [7:0]            reg_ptr,
	// Sample stream from the input shifter
	input  wire logic                  in_valid,
	output logic                       in_ready,
	input  wire adcr_pkg::adcr_sample_s in_sample,
	// Sample stream to the delay memory
	output logic                       out_valid,
	input  wire logic                  out_ready,
	output adcr_pkg::adcr_sample_s     out_sample,
	// Settings in force
	output adcr_pkg::adcr_setting_s    active,
	output logic                       mute_left,
	output logic                       mute_right,
	output logic                       settings_update
);
	typedef struct packed {
		logic [7:0]                          ptr;
		logic [7:0]                          ctrl;
		logic [adcr_pkg::ADCR_HIGH_W-1:0]    r_high;
		logic [7:0]                          r_low;
		logic [adcr_pkg::ADCR_HIGH_W-1:0]    l_high;
		logic [7:0]                          l_low;
		logic [7:0]                          frame;
		logic [7:0]                          word_len;
		logic [7:0]                          commit;
		logic [7:0]                          rd_data;
		adcr_pkg::adcr_setting_s             active;
		logic                                update;
	} adcr_state_s;

	adcr_state_s state_reg;
	adcr_state_s state_next;

	logic [7:0]                            rd_mux;
	logic [adcr_pkg::ADCR_FS_SEL_W-1:0]    fs_sel;
	logic [adcr_pkg::ADCR_NFRAME_W:0]      frames;
	logic [adcr_pkg::ADCR_PROD_W-1:0]      frame_prod;
	logic [adcr_pkg::ADCR_PROD_W-1:0]      frame_samples;
	logic [adcr_pkg::ADCR_DELAY_W-1:0]     frame_delay;
	logic [adcr_pkg::ADCR_DELAY_W-1:0]     commit_r;
	logic [adcr_pkg::ADCR_DELAY_W-1:0]     commit_l;
	typedef logic [adcr_pkg::ADCR_FMT_W-1:0] adcr_fmt_w_t;

	logic [adcr_pkg::ADCR_PROD_W-1:0]      fs_wide;
	logic [adcr_pkg::ADCR_WORDLEN_W-1:0]   wl_field;
	adcr_fmt_w_t                           fmt_field;
	adcr_pkg::adcr_sample_s                fifo_in;
	logic                                  is_muted;

	// Read view of the register file
	always_comb
	begin
		case (state_reg.ptr)
			adcr_pkg::ADCR_OFS_CTRL:    rd_mux = state_reg.ctrl;
			adcr_pkg::ADCR_OFS_R_HIGH:  rd_mux = {3'h0, state_reg.r_high}; // [RL19]
			adcr_pkg::ADCR_OFS_R_LOW:   rd_mux = state_reg.r_low;
			adcr_pkg::ADCR_OFS_L_HIGH:  rd_mux = {3'h0, state_reg.l_high}; // [RL19]
			adcr_pkg::ADCR_OFS_L_LOW:   rd_mux = state_reg.l_low;
			adcr_pkg::ADCR_OFS_FRAME:   rd_mux = state_reg.frame;
			adcr_pkg::ADCR_OFS_WORDLEN: rd_mux = state_reg.word_len;
			adcr_pkg::ADCR_OFS_COMMIT:  rd_mux = state_reg.commit;
			default:                    rd_mux = adcr_pkg::ADCR_UNMAPPED_RD;
		endcase
	end

	// Frame-to-sample conversion from the stored frame register
	always_comb
	begin
		fs_sel = state_reg.frame[adcr_pkg::ADCR_FS_SEL_LSB +: adcr_pkg::ADCR_FS_SEL_W]; // [RL13]
		frames = {1'b0, state_reg.frame[adcr_pkg::ADCR_NFRAME_LSB +: adcr_pkg::ADCR_NFRAME_W]}
			+ 4'h1; // [RL14]
		// Operands widened first so no partial product wraps
		fs_wide = adcr_pkg::ADCR_PROD_W'(adcr_pkg::ADCR_FS_100HZ[fs_sel]) * adcr_pkg::ADCR_PROD_W'(frames);
		if (state_reg.frame[adcr_pkg::ADCR_FRAME_59_BIT]) // [RL12]
		begin
			// Multiply before dividing so only the final result is truncated
			frame_prod    = fs_wide * adcr_pkg::ADCR_PROD_W'(adcr_pkg::ADCR_MUL_59);
			frame_samples = frame_prod / adcr_pkg::ADCR_DIV_59; // [RL15]
		end
		else
		begin
			frame_prod    = fs_wide * adcr_pkg::ADCR_PROD_W'(adcr_pkg::ADCR_MUL_50);
			frame_samples = frame_prod; // [RL15]
		end
		if (frame_samples > adcr_pkg::ADCR_PROD_W'(adcr_pkg::ADCR_DELAY_MAX))
			frame_delay = adcr_pkg::ADCR_DELAY_MAX; // [RL16]
		else
			frame_delay = frame_samples[adcr_pkg::ADCR_DELAY_W-1:0];
	end

	// Values that a commit hands to the delay function
	always_comb
	begin
		if (state_reg.frame[adcr_pkg::ADCR_FRAME_EN_BIT]) // [RL11]
		begin
			commit_r = frame_delay;
			commit_l = frame_delay;
		end
		else
		begin
			commit_r = {state_reg.r_high, state_reg.r_low}; // [RL3] [RL7] [RL8]
			commit_l = {state_reg.l_high, state_reg.l_low}; // [RL3] [RL7] [RL8]
		end
		fmt_field = state_reg.ctrl[adcr_pkg::ADCR_FMT_LSB +: adcr_pkg::ADCR_FMT_W]; // [RL5]
		wl_field  = state_reg.word_len[adcr_pkg::ADCR_WORDLEN_W-1:0];
		if (wl_field > adcr_pkg::ADCR_WORDLEN_MAX)
			wl_field = adcr_pkg::ADCR_WORDLEN_MAX;
	end

	always_comb
	begin
		state_next        = state_reg;
		state_next.update = 1'b0;
		if (reg_addr_load)
			state_next.ptr = reg_addr_in;
		else if (reg_wr_stb)
		begin
			case (state_reg.ptr)
				adcr_pkg::ADCR_OFS_CTRL:    state_next.ctrl = reg_wr_data; // [RL4]
				adcr_pkg::ADCR_OFS_R_HIGH:  state_next.r_high = reg_wr_data[adcr_pkg::ADCR_HIGH_W-1:0]; // [RL19]
				adcr_pkg::ADCR_OFS_R_LOW:   state_next.r_low = reg_wr_data;
				adcr_pkg::ADCR_OFS_L_HIGH:  state_next.l_high = reg_wr_data[adcr_pkg::ADCR_HIGH_W-1:0]; // [RL19]
				adcr_pkg::ADCR_OFS_L_LOW:   state_next.l_low = reg_wr_data;
				adcr_pkg::ADCR_OFS_FRAME:   state_next.frame = reg_wr_data;
				adcr_pkg::ADCR_OFS_WORDLEN: state_next.word_len = reg_wr_data;
				adcr_pkg::ADCR_OFS_COMMIT:  state_next.commit = reg_wr_data;
				default:                    state_next.commit = state_reg.commit;
			endcase
			// Commit uses settings already stored, so write it last in a burst
			if (state_reg.ptr == adcr_pkg::ADCR_OFS_COMMIT && reg_wr_data[adcr_pkg::ADCR_COMMIT_BIT])
			begin
				state_next.active.format      = adcr_pkg::adcr_fmt_e'(fmt_field); // [RL17]
				state_next.active.bypass      = (fmt_field == 2'(adcr_pkg::ADCR_FMT_BYPASS)); // [RL6]
				state_next.active.word_len    = wl_field; // [RL17]
				state_next.active.delay_right = commit_r; // [RL9] [RL17]
				state_next.active.delay_left  = commit_l; // [RL9] [RL17]
				state_next.update             = 1'b1;
			end
			state_next.ptr = state_reg.ptr + 8'h01;
		end
		else if (reg_rd_stb)
		begin
			state_next.rd_data = rd_mux; // [RL2]
			state_next.ptr     = state_reg.ptr + 8'h01; // [RL2]
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg          <= '0;
			state_reg.ctrl     <= adcr_pkg::ADCR_RST_BYTE;
			state_reg.frame    <= adcr_pkg::ADCR_RST_BYTE;
			state_reg.word_len <= adcr_pkg::ADCR_RST_BYTE;
			state_reg.commit   <= adcr_pkg::ADCR_RST_BYTE;
		end
		else
			state_reg <= state_next;
	end

	// Mute follows the control register at once, no commit needed
	assign mute_left  = state_reg.ctrl[adcr_pkg::ADCR_MUTE_L_BIT]; // [RL4] [RL17]
	assign mute_right = state_reg.ctrl[adcr_pkg::ADCR_MUTE_R_BIT]; // [RL4] [RL17]

	// Zeroing before the FIFO keeps slot timing intact and data from flops
	assign is_muted     = in_sample.right ? mute_right : mute_left;
	assign fifo_in.right = in_sample.right;
	assign fifo_in.data  = is_muted ? '0 : in_sample.data; // [RL18]

	adcr_fifo #(
		.WIDTH ($bits(adcr_pkg::adcr_sample_s)),
		.DEPTH (adcr_pkg::ADCR_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   (fifo_in),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_sample)
	);

	assign reg_rd_data     = state_reg.rd_data;
	assign reg_ptr         = state_reg.ptr;
	assign active          = state_reg.active;
	assign settings_update = state_reg.update;
endmodule // adcr_bank

`default_nettype wire

//--- verification/adcr_chk_asserts.sv
// Port assertions for the audio delay register bank
`timescale 1ns/1ps
`default_nettype none
module adcr_chk (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire logic                    reg_addr_load,
	input wire logic [7:0]              reg_addr_in,
	input wire logic                    reg_wr_stb,
	input wire logic [7:0]              reg_wr_data,
	input wire logic                    reg_rd_stb,
	input wire logic [7:0]              reg_rd_data,
	input wire logic [7:0]              reg_ptr,
	input wire adcr_pkg::adcr_setting_s active,
	input wire logic                    mute_left,
	input wire logic                    mute_right,
	input wire logic                    settings_update
);
	logic       ctrl_wr;
	logic       commit;
	logic       rd_go;
	logic [7:0] last_ctrl;
	assign ctrl_wr = reg_wr_stb && !reg_addr_load && reg_ptr == adcr_pkg::ADCR_OFS_CTRL;
	assign commit = reg_wr_stb && !reg_addr_load && reg_ptr == adcr_pkg::ADCR_OFS_COMMIT && reg_wr_data[0];
	assign rd_go = reg_rd_stb && !reg_addr_load && !reg_wr_stb;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			last_ctrl <= 8'h00;
		else if (ctrl_wr)
			last_ctrl <= reg_wr_data;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_load; reg_addr_load |=> reg_ptr == $past(reg_addr_in); endproperty
	a_load: assert property (p_load) else $error("pointer not loaded");
	property p_inc; !reg_addr_load && (reg_wr_stb || reg_rd_stb) |=> reg_ptr == $past(reg_ptr) + 8'h01; endproperty
	a_inc: assert property (p_inc) else $error("pointer did not advance");
	property p_upd; commit |=> settings_update; endproperty
	a_upd: assert property (p_upd) else $error("commit gave no update");
	property p_cause; settings_update |-> $past(commit); endproperty
	a_cause: assert property (p_cause) else $error("update without commit");
	property p_hold; !settings_update |-> $stable(active); endproperty
	a_hold: assert property (p_hold) else $error("settings moved without commit");
	property p_mute; !ctrl_wr && !$past(ctrl_wr) |-> {mute_right, mute_left} == last_ctrl[7:6]; endproperty
	a_mute: assert property (p_mute) else $error("mute differs from control");
	property p_byp; active.bypass == (active.format == adcr_pkg::ADCR_FMT_BYPASS); endproperty
	a_byp: assert property (p_byp) else $error("bypass flag wrong");
	property p_hi; rd_go && (reg_ptr == 8'h02 || reg_ptr == 8'h04) |=> reg_rd_data[7:5] == 3'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper delay spare bits set");
	property p_unm; rd_go && (reg_ptr == 8'h00 || reg_ptr > 8'h08) |=> reg_rd_data == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // adcr_chk
bind adcr_bank adcr_chk u_chk (.clk, .rst_n, .reg_addr_load, .reg_addr_in, .reg_wr_stb, .reg_wr_data,
	.reg_rd_stb, .reg_rd_data, .reg_ptr, .active, .mute_left, .mute_right, .settings_update);
`default_nettype wire

//--- verification/adcr_host.sv
// Host side model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module adcr_host (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rd_data,
	output logic            reg_addr_load,
	output logic      [7:0] reg_addr_in,
	output logic            reg_wr_stb,
	output logic      [7:0] reg_wr_data,
	output logic            reg_rd_stb
);
	initial
	begin
		{reg_addr_load, reg_wr_stb, reg_rd_stb} = 3'h0;
		reg_addr_in = 8'h00;
		reg_wr_data = 8'h00;
	end
	// Idle lines inverted so stale values cannot pass as data
	task automatic op(input logic [2:0] k, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1;
		{reg_addr_load, reg_wr_stb, reg_rd_stb} = k;
		reg_addr_in = d;
		reg_wr_data = d;
		@(posedge clk);
		#1;
		q = reg_rd_data;
		{reg_addr_load, reg_wr_stb, reg_rd_stb} = 3'h0;
		reg_addr_in = ~d;
		reg_wr_data = ~d;
	endtask
	task automatic wr_burst(input logic [7:0] a, input logic [7:0] b[$]);
		logic [7:0] x;
		op(3'h4, a, x);
		foreach (b[i]) op(3'h2, b[i], x);
	endtask
	// Stops after the last byte, as the engine does on the host's refusal
	task automatic rd_burst(input logic [7:0] a, input int n, output logic [7:0] q[$]);
		logic [7:0] x;
		q = {};
		op(3'h4, a, x);
		for (int i = 0; i < n; i++)
		begin
			op(3'h1, 8'h00, x);
			q.push_back(x);
		end
	endtask
endmodule // adcr_host
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the audio delay register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                    clk;
	logic                    rst_n;
	logic                    ld;
	logic                    wr;
	logic                    rd;
	logic [7:0]              ain;
	logic [7:0]              wdat;
	logic [7:0]              rdat;
	logic [7:0]              ptr;
	logic                    in_valid;
	logic                    in_ready;
	logic                    out_valid;
	logic                    out_ready;
	adcr_pkg::adcr_sample_s  in_sample;
	adcr_pkg::adcr_sample_s  out_sample;
	adcr_pkg::adcr_setting_s active;
	logic                    mute_left;
	logic                    mute_right;
	logic                    upd;
	logic [7:0]              rq[$];
	int                      fails;
	int                      n_checks;
	int                      cyc;
	adcr_host host (.clk(clk), .reg_rd_data(rdat), .reg_addr_load(ld), .reg_addr_in(ain), .reg_wr_stb(wr),
		.reg_wr_data(wdat), .reg_rd_stb(rd));
	adcr_bank dut (.clk(clk), .rst_n(rst_n), .reg_addr_load(ld), .reg_addr_in(ain), .reg_wr_stb(wr),
		.reg_wr_data(wdat), .reg_rd_stb(rd), .reg_rd_data(rdat), .reg_ptr(ptr), .in_valid(in_valid),
		.in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid), .out_ready(out_ready),
		.out_sample(out_sample), .active(active), .mute_left(mute_left), .mute_right(mute_right),
		.settings_update(upd));
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			stop_test();
		end
	end
	task automatic cmp(input string nm, input logic [24:0] e, input logic [24:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic commit_settle();
		host.wr_burst(8'h08, '{8'h01});
		cmp("update pulse", 1'b1, upd);
		@(posedge clk);
		#1;
		cmp("update ends", 1'b0, upd);
	endtask
	function automatic logic [12:0] frame_exp(input logic [7:0] f);
		longint fs[8] = '{32'h7d00, 32'hac44, 32'hbb80, 32'h15888, 32'h17700, 32'h2b110, 32'h2ee00, 32'h2ee00};
		longint d;
		d = (f[2:0] + 32'h1) * fs[f[5:3]];
		d = f[6] ? d * 32'h3e9 / 32'hea60 : d / 32'h32;
		return (d > 32'h1fff) ? 13'h1fff : d[12:0];
	endfunction
	initial
	begin
		{rst_n, in_valid, out_ready} = 3'h0;
		in_sample = '0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		host.rd_burst(8'h00, 10, rq);
		foreach (rq[i]) cmp("reset byte", 8'h00, rq[i]);
		host.wr_burst(8'h01, '{8'h01, 8'hff, 8'hff, 8'h00, 8'h01, 8'h00, 8'h3f});
		host.rd_burst(8'h01, 7, rq);
		foreach (rq[i]) cmp("readback", i == 1 ? 8'h1f : i == 6 ? 8'h3f : i == 2 ? 8'hff : i[0] ? 8'h00 : 8'h01, rq[i]);
		cmp("delay before commit", 13'h0, active.delay_right);
		commit_settle();
		cmp("pointer", 8'h09, ptr);
		cmp("right delay", 13'h1fff, active.delay_right);
		cmp("left delay", 13'h0001, active.delay_left);
		cmp("format", adcr_pkg::ADCR_FMT_RIGHT_JUSTIFIED, active.format);
		cmp("word length", 6'h18, active.word_len);
		for (int i = 0; i < 4; i++)
		begin
			host.wr_burst(8'h01, '{{i[1:0], 4'h0, i[1:0]}});
			repeat (2) @(posedge clk);
			#1;
			cmp("mute", i[1:0], {mute_right, mute_left});
			commit_settle();
			cmp("format", i[1:0], active.format);
			cmp("bypass", i == 3, active.bypass);
		end
		for (int k = 0; k < 8; k++)
		begin
			host.wr_burst(8'h06, '{{1'b1, k[0], k[2:0], k[2:0]}});
			commit_settle();
			cmp("frame right", frame_exp({1'b1, k[0], k[2:0], k[2:0]}), active.delay_right);
			cmp("frame left", frame_exp({1'b1, k[0], k[2:0], k[2:0]}), active.delay_left);
		end
		host.wr_burst(8'h06, '{8'h7f});
		commit_settle();
		cmp("frame off", 13'h1fff, active.delay_right);
		cmp("frame off left", 13'h0001, active.delay_left);
		host.wr_burst(8'h01, '{8'h80});
		repeat (2) @(posedge clk);
		#1;
		in_valid = 1'b1;
		for (int i = 0; i < 33; i++)
		begin
			in_sample = {i[0], 24'ha50000 + i[23:0]};
			@(posedge clk);
			#1;
		end
		in_valid = 1'b0;
		cmp("full refuses", 1'b0, in_ready);
		out_ready = 1'b1;
		for (int i = 0; i < 32; i++)
		begin
			cmp("out valid", 1'b1, out_valid);
			cmp("out sample", {i[0], i[0] ? 24'h0 : 24'ha50000 + i[23:0]}, out_sample);
			@(posedge clk);
			#1;
		end
		cmp("drained", 1'b0, out_valid);
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		cmp("reset delay", 13'h0, active.delay_right);
		cmp("reset mute", 2'h0, {mute_right, mute_left});
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
